// *** hwsf_pkg.sv ***
// Constants shared by the hit word serial framer, its checks and its bench.
// Assumes one system clock that is also the serializer transmit clock.
package hwsf_pkg;

   // Frame geometry
   localparam int HIT_W = 64;
   localparam int WORD_W = 16;
   localparam int CNT_W = 16;
   localparam int FRAME_W = 80;
   localparam int WORDS_PER_FRAME = 6;
   localparam int HIT_WORDS = 4;

   // Word positions within a frame on the serializer
   localparam logic [2:0] WORD_FIRST = 3'h0;
   localparam logic [2:0] WORD_COUNT = 3'h4;
   localparam logic [2:0] WORD_CEXT = 3'h5;

   // Carrier-extend filler word, value arbitrary
   localparam logic [15:0] CARRIER_EXT_WORD = 16'hC5C5;

   // Reset values
   localparam logic [15:0] BEAM_CNT_RESET = 16'h0000;
   localparam logic [15:0] TX_IDLE_WORD = 16'h0000;
   localparam logic [7:0] DAC_RESET_CODE = 8'h00;
   localparam logic [5:0] DAC_CH_RESET = 6'h00;

   // Threshold DAC scale
   localparam int DAC_CODE_W = 8;
   localparam int DAC_CH_W = 6;
   localparam int DAC_CHANNELS = 64;
   localparam int DAC_STEP_MV = 2;
   localparam int DAC_FULL_MV = 512;
   localparam logic [5:0] DAC_CH_LAST = 6'h3F;

   // Timing
   localparam int SYS_CLK_KHZ = 40000;
   localparam int BEAM_PERIOD_NS = 106;
   localparam int BEAM_PERIOD_CYC = (BEAM_PERIOD_NS * SYS_CLK_KHZ) / 1000000;

   // Slow-control command word fields
   localparam int OP_MSB = 15;
   localparam int OP_LSB = 14;
   localparam int CH_MSB = 13;
   localparam int CH_LSB = 8;
   localparam int CODE_MSB = 7;
   localparam int CODE_LSB = 0;

   // Slow-control opcodes
   localparam logic [1:0] OP_NOP = 2'h0;
   localparam logic [1:0] OP_SET = 2'h1;
   localparam logic [1:0] OP_INIT = 2'h2;
   localparam logic [1:0] OP_RESET = 2'h3;

   typedef enum logic [0:0] {
      SC_IDLE = 1'b0,
      SC_WALK = 1'b1
   } hwsf_sc_e;

endpackage : hwsf_pkg

// *** hwsf_fifo.sv ***
// Frame buffer between hit capture and the word serializer.
// Assumes a single clock and synchronous active-high clear.
`timescale 1ns/100ps
module hwsf_fifo #(
   parameter int WIDTH = 80,
   parameter int DEPTH = 4
) (
   input wire logic clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   generate
      if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
         $error("hwsf_fifo DEPTH must be a power of two, at least 2");
      end
   endgenerate

   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0] wr_q;
   logic [AW:0] rd_q;
   wire full = (wr_q[AW] != rd_q[AW]) && (wr_q[AW-1:0] == rd_q[AW-1:0]);
   wire empty = (wr_q == rd_q);
   wire push = in_valid && !full;
   wire pop = out_ready && !empty;

   assign in_ready = !full;
   assign out_valid = !empty;
   assign out_data = mem_q[rd_q[AW-1:0]];

   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   always_ff @(posedge clk) begin
      if (srst) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end

endmodule : hwsf_fifo

// *** hwsf_framer.sv ***
// Hit word serial framer: captures 64 hit bits per beam clock, frames
// them with a beam count and a carrier-extend word, sends 16-bit words
// to the serializer and drives the per-channel threshold DACs from
// slow-control words arriving on the deserializer side.
// Assumes all inputs synchronous to SYS_CLK, the transmit clock.
`timescale 1ns/100ps

module hwsf_framer #(
   parameter int FIFO_DEPTH = 4
) (
   input wire logic SYS_CLK,
   input wire logic SRST,
   input wire logic BEAM_CLK,
   input wire logic [63:0] HITS,
   output logic [15:0] TX_DATA,
   output logic TX_EN,
   input wire logic [15:0] RX_DATA,
   input wire logic RX_VALID,
   output logic [5:0] DAC_CH,
   output logic [7:0] DAC_CODE,
   output logic DAC_WR,
   output logic OVERFLOW,
   output logic SC_BUSY
);

   generate
      if (FIFO_DEPTH < 2 || FIFO_DEPTH > 64) begin : g_bad_param
         $error("hwsf_framer FIFO_DEPTH out of range");
      end
   endgenerate

   // Word of a frame at a given position
   function automatic logic [15:0] frame_word(
      input logic [79:0] f,
      input logic [2:0] i
   );
      logic [15:0] w;
      w = hwsf_pkg::CARRIER_EXT_WORD;
      case (i)
         3'h0: w = f[15:0];
         3'h1: w = f[31:16];
         3'h2: w = f[47:32];
         3'h3: w = f[63:48];
         hwsf_pkg::WORD_COUNT: w = f[79:64];
         default: w = hwsf_pkg::CARRIER_EXT_WORD;
      endcase
      return w;
   endfunction : frame_word

   // ---------------- Beam clock capture ----------------
   logic beam_q;
   logic [15:0] beam_cnt_q;
   logic [15:0] beam_cnt_d;
   logic overflow_q;
   logic flush_q;
   logic sc_clear;

   // Beam clock is sampled as a level; a rising edge opens a new frame
   wire beam_rise = BEAM_CLK && !beam_q;
   wire cap_valid = beam_rise;
   wire [79:0] cap_frame = {beam_cnt_q, HITS};
   wire cap_ready;

   assign beam_cnt_d = beam_cnt_q + 16'h0001;

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         beam_q <= 1'b0;
      end else begin
         beam_q <= BEAM_CLK;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST || flush_q) begin
         beam_cnt_q <= hwsf_pkg::BEAM_CNT_RESET;
      end else if (beam_rise) begin
         beam_cnt_q <= beam_cnt_d;
      end
   end

   // ---------------- Frame buffer ----------------
   logic buf_valid;
   logic buf_ready;
   logic [79:0] buf_frame;

   // Flush the cycle after the reset command; TX_DATA can still take one last frame word at the flush edge
   hwsf_fifo #(
      .WIDTH(hwsf_pkg::FRAME_W),
      .DEPTH(FIFO_DEPTH)
   ) u_fifo (
      .clk(SYS_CLK),
      .srst(SRST || flush_q),
      .in_valid(cap_valid),
      .in_ready(cap_ready),
      .in_data(cap_frame),
      .out_valid(buf_valid),
      .out_ready(buf_ready),
      .out_data(buf_frame)
   );

   // ---------------- Word serializer ----------------
   logic busy_q;
   logic [2:0] word_q;
   logic [79:0] frame_q;
   logic [15:0] tx_data_q;
   logic tx_en_q;

   wire last_word = (word_q == hwsf_pkg::WORD_CEXT);
   // Next frame is taken back to back with the last word of the current one
   assign buf_ready = !busy_q || last_word;

   always_ff @(posedge SYS_CLK) begin
      if (SRST || flush_q) begin
         busy_q <= 1'b0;
         word_q <= hwsf_pkg::WORD_FIRST;
         frame_q <= '0;
      end else if (buf_ready && buf_valid) begin
         busy_q <= 1'b1;
         word_q <= hwsf_pkg::WORD_FIRST;
         frame_q <= buf_frame;
      end else if (busy_q) begin
         busy_q <= !last_word;
         word_q <= word_q + 3'h1;
      end
   end

   // Output register carries one frame word per cycle while busy, the idle word otherwise
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         tx_data_q <= hwsf_pkg::TX_IDLE_WORD;
         tx_en_q <= 1'b0;
      end else if (busy_q) begin
         tx_data_q <= frame_word(frame_q, word_q);
         tx_en_q <= 1'b1;
      end else begin
         tx_data_q <= hwsf_pkg::TX_IDLE_WORD;
         tx_en_q <= 1'b0;
      end
   end

   assign TX_DATA = tx_data_q;
   assign TX_EN = tx_en_q;

   // Overflow is sticky; a frame lost in the clearing cycle still sets it
   wire cap_lost = cap_valid && !cap_ready;

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         overflow_q <= 1'b0;
      end else if (cap_lost) begin
         overflow_q <= 1'b1;
      end else if (sc_clear) begin
         overflow_q <= 1'b0;
      end
   end

   assign OVERFLOW = overflow_q;

   // ---------------- Slow control and threshold DACs ----------------
   hwsf_pkg::hwsf_sc_e sc_q;
   logic [7:0] thr_q [hwsf_pkg::DAC_CHANNELS];
   logic [5:0] walk_q;
   logic [5:0] dac_ch_q;
   logic [7:0] dac_code_q;
   logic dac_wr_q;

   wire [1:0] rx_op = RX_DATA[hwsf_pkg::OP_MSB:hwsf_pkg::OP_LSB];
   wire [5:0] rx_ch = RX_DATA[hwsf_pkg::CH_MSB:hwsf_pkg::CH_LSB];
   wire [7:0] rx_code = RX_DATA[hwsf_pkg::CODE_MSB:hwsf_pkg::CODE_LSB];
   // Commands are only taken while no reload walk is running
   wire sc_take = RX_VALID && (sc_q == hwsf_pkg::SC_IDLE);
   wire cmd_set = sc_take && (rx_op == hwsf_pkg::OP_SET);
   wire cmd_init = sc_take && (rx_op == hwsf_pkg::OP_INIT);
   wire cmd_reset = sc_take && (rx_op == hwsf_pkg::OP_RESET);
   assign sc_clear = cmd_init || cmd_reset;
   wire walk_last = (walk_q == hwsf_pkg::DAC_CH_LAST);

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         flush_q <= 1'b0;
      end else begin
         flush_q <= cmd_reset;
      end
   end

   // Threshold table; reset command returns every channel to zero
   always_ff @(posedge SYS_CLK) begin
      if (SRST || cmd_reset) begin
         for (int i = 0; i < hwsf_pkg::DAC_CHANNELS; i++) begin
            thr_q[i] <= hwsf_pkg::DAC_RESET_CODE;
         end
      end else if (cmd_set) begin
         thr_q[rx_ch] <= rx_code;
      end
   end

   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         sc_q <= hwsf_pkg::SC_IDLE;
         walk_q <= hwsf_pkg::DAC_CH_RESET;
      end else begin
         case (sc_q)
            hwsf_pkg::SC_IDLE: begin
               if (sc_clear) begin
                  sc_q <= hwsf_pkg::SC_WALK;
                  walk_q <= hwsf_pkg::DAC_CH_RESET;
               end
            end
            hwsf_pkg::SC_WALK: begin
               walk_q <= walk_q + 6'h01;
               if (walk_last) begin
                  sc_q <= hwsf_pkg::SC_IDLE;
               end
            end
            default: begin
               sc_q <= hwsf_pkg::SC_IDLE;
            end
         endcase
      end
   end

   // One DAC write per direct set, or per channel during a reload walk
   always_ff @(posedge SYS_CLK) begin
      if (SRST) begin
         dac_ch_q <= hwsf_pkg::DAC_CH_RESET;
         dac_code_q <= hwsf_pkg::DAC_RESET_CODE;
         dac_wr_q <= 1'b0;
      end else if (sc_q == hwsf_pkg::SC_WALK) begin
         dac_ch_q <= walk_q;
         dac_code_q <= thr_q[walk_q];
         dac_wr_q <= 1'b1;
      end else if (cmd_set) begin
         dac_ch_q <= rx_ch;
         dac_code_q <= rx_code;
         dac_wr_q <= 1'b1;
      end else begin
         dac_wr_q <= 1'b0;
      end
   end

   assign DAC_CH = dac_ch_q;
   assign DAC_CODE = dac_code_q;
   assign DAC_WR = dac_wr_q;
   assign SC_BUSY = (sc_q == hwsf_pkg::SC_WALK);

endmodule : hwsf_framer

// *** hwsf_framer_asserts.sv ***
// Port-level checks for the hit word serial framer.
// Bound into every hwsf_framer; one transmit clock domain.
`timescale 1ns/100ps
module hwsf_framer_asserts (
   input wire logic SYS_CLK,
   input wire logic SRST,
   input wire logic BEAM_CLK,
   input wire logic [63:0] HITS,
   input wire logic [15:0] TX_DATA,
   input wire logic TX_EN,
   input wire logic [15:0] RX_DATA,
   input wire logic RX_VALID,
   input wire logic [5:0] DAC_CH,
   input wire logic [7:0] DAC_CODE,
   input wire logic DAC_WR,
   input wire logic OVERFLOW,
   input wire logic SC_BUSY
);
   logic [6:0] busy_n_q;
   logic [6:0] busy_n_d;
   logic srst_q;
   logic take;
   logic [1:0] op;
   assign take = RX_VALID && !SC_BUSY;
   assign op = RX_DATA[15:14];
   assign busy_n_d = SC_BUSY ? busy_n_q + 7'h01 : 7'h00;
   always_ff @(posedge SYS_CLK) begin
      busy_n_q <= SRST ? 7'h00 : busy_n_d;
      srst_q <= SRST;
   end
   default clocking cb @(posedge SYS_CLK);
   endclocking
   default disable iff (SRST);
   // A reset command flushes the link, so frame checks pause while busy
   // Link still idle two edges after the beam edge: first word one later
   a_first_word: assert property (disable iff (SRST || SC_BUSY)
      $rose(BEAM_CLK) ##2 !TX_EN |=> TX_EN
      && TX_DATA == $past(HITS[15:0], 3)) else $error("first word");
   a_hit_words: assert property (disable iff (SRST || SC_BUSY)
      $rose(TX_EN) |=> TX_DATA == $past(HITS[31:16], 4)
      ##1 TX_DATA == $past(HITS[47:32], 5)
      ##1 TX_DATA == $past(HITS[63:48], 6)) else $error("hit words");
   a_frame_len: assert property (disable iff (SRST || SC_BUSY)
      $rose(TX_EN) |-> TX_EN [*6]) else $error("frame length");
   a_carrier_word: assert property (disable iff (SRST || SC_BUSY)
      $rose(TX_EN) |-> ##5 TX_DATA == hwsf_pkg::CARRIER_EXT_WORD)
      else $error("carrier word");
   a_set_write: assert property (take && op == hwsf_pkg::OP_SET
      |=> DAC_WR && DAC_CH == $past(RX_DATA[13:8])
      && DAC_CODE == $past(RX_DATA[7:0])) else $error("set write");
   a_walk_start: assert property (take && op == hwsf_pkg::OP_INIT
      |=> SC_BUSY ##1 DAC_WR && DAC_CH == 6'h00) else $error("walk");
   a_reset_walk: assert property (take && op == hwsf_pkg::OP_RESET
      |-> ##2 DAC_WR && DAC_CODE == 8'h00 ##63 DAC_WR
      && DAC_CH == 6'h3F && DAC_CODE == 8'h00) else $error("reset walk");
   a_busy_len: assert property ($fell(SC_BUSY) && !srst_q
      |-> busy_n_q == 7'h40) else $error("busy length");
   a_ovf_clear: assert property ($fell(OVERFLOW) && !srst_q
      |-> SC_BUSY) else $error("overflow cleared alone");
   c_frame: cover property ($rose(TX_EN));
   c_walk: cover property ($fell(SC_BUSY));
   c_drop: cover property ($rose(OVERFLOW));
endmodule : hwsf_framer_asserts

bind hwsf_framer hwsf_framer_asserts hwsf_framer_asserts_i (
   .SYS_CLK(SYS_CLK), .SRST(SRST), .BEAM_CLK(BEAM_CLK), .HITS(HITS),
   .TX_DATA(TX_DATA), .TX_EN(TX_EN), .RX_DATA(RX_DATA),
   .RX_VALID(RX_VALID), .DAC_CH(DAC_CH), .DAC_CODE(DAC_CODE),
   .DAC_WR(DAC_WR), .OVERFLOW(OVERFLOW), .SC_BUSY(SC_BUSY));

// *** hwsf_serdes_model.sv ***
// Serializer stand-in at the framer's link pins.
// Shares the transmit clock; the bench calls send and reads got.
`timescale 1ns/100ps
module hwsf_serdes_model (
   input wire logic clk,
   input wire logic [15:0] tx_data,
   input wire logic tx_en,
   output logic [15:0] rx_data,
   output logic rx_valid
);
   logic [15:0] got [$];
   initial begin
      rx_data = 16'hFFFF;
      rx_valid = 1'b0;
   end
   // Taken mid-cycle, away from the edge that moves the framer outputs
   always @(negedge clk) begin
      if (tx_en === 1'b1) begin
         got.push_back(tx_data);
      end
   end
   // Idle receive data shows a stale inverse, never a real command
   task automatic send(input logic [15:0] w);
      @(posedge clk);
      #1;
      rx_data = w;
      rx_valid = 1'b1;
      @(posedge clk);
      #1;
      rx_data = ~w;
      rx_valid = 1'b0;
   endtask : send
endmodule : hwsf_serdes_model

// *** hwsf_framer_test.sv ***
// Self-checking bench for the hit word serial framer.
// Inputs move 1 ns after the rising edge; the link partner is a model.
`timescale 1ns/100ps
module hwsf_framer_test;
   logic sys_clk = 1'b0;
   logic srst = 1'b1;
   logic beam_clk = 1'b0;
   logic [63:0] hits = 64'h0;
   logic [15:0] tx_data;
   logic [15:0] rx_data;
   logic tx_en, rx_valid, dac_wr, overflow, sc_busy;
   logic [5:0] dac_ch;
   logic [7:0] dac_code;
   logic [7:0] thr [64] = '{default: 8'h00};
   logic [15:0] q [$];
   logic [15:0] exp_cnt = 16'h0;
   int n_wr = 0;
   int fails = 0;
   int n_compared = 0;
   always #12.5 sys_clk = ~sys_clk;
   // DAC outputs are taken mid-cycle, where they are settled
   always @(negedge sys_clk) begin
      if (dac_wr === 1'b1) begin
         thr[dac_ch] <= dac_code;
         n_wr <= n_wr + 1;
      end
   end
   hwsf_framer #(.FIFO_DEPTH(2)) hwsf_framer_i (
      .SYS_CLK(sys_clk), .SRST(srst), .BEAM_CLK(beam_clk), .HITS(hits),
      .TX_DATA(tx_data), .TX_EN(tx_en), .RX_DATA(rx_data),
      .RX_VALID(rx_valid), .DAC_CH(dac_ch), .DAC_CODE(dac_code),
      .DAC_WR(dac_wr), .OVERFLOW(overflow), .SC_BUSY(sc_busy));
   hwsf_serdes_model hwsf_serdes_model_i (.clk(sys_clk),
      .tx_data(tx_data), .tx_en(tx_en), .rx_data(rx_data),
      .rx_valid(rx_valid));
   task automatic check(input string what, input logic [15:0] seen,
         input logic [15:0] exp);
      n_compared++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %s exp %h seen %h", what, exp, seen);
      end
   endtask : check
   task automatic summarize();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : summarize
   task automatic cyc(input int n);
      repeat (n) @(posedge sys_clk);
      #1;
   endtask : cyc
   // Beam period is 2*half clocks; 8 lets the link keep up, t_overflow uses 2 to overrun it
   task automatic beat(input logic [63:0] h, input int half);
      hits = h;
      beam_clk = 1'b1;
      cyc(half);
      beam_clk = 1'b0;
      cyc(half);
   endtask : beat
   task automatic settle();
      int i;
      for (i = 0; i < 200 && (tx_en !== 1'b0 || sc_busy !== 1'b0); i++)
         cyc(1);
      if (i == 200) begin
         check("timeout", 16'h1, 16'h0);
         summarize();
      end
      cyc(2);
      q = hwsf_serdes_model_i.got;
   endtask : settle
   task automatic frm(input logic [63:0] h, input int b);
      for (int w = 0; w < 4; w++)
         check("hit", q[b+w], h[16*w +: 16]);
      check("count", q[b+4], exp_cnt);
      check("cext", q[b+5], hwsf_pkg::CARRIER_EXT_WORD);
      exp_cnt++;
   endtask : frm
   task automatic t_frames();
      logic [63:0] h [3] = '{64'h0123_4567_89AB_CDEF,
         64'hFFFF_0000_A5A5_0001, 64'h8000_0000_0000_0001};
      check("idle", tx_data, hwsf_pkg::TX_IDLE_WORD);
      foreach (h[i]) beat(h[i], 4);
      settle();
      check("words", 16'(q.size()), 16'h0012);
      foreach (h[i]) frm(h[i], 6 * i);
   endtask : t_frames
   // Set on both end channels and both end codes, then a no-op
   task automatic t_set();
      logic [15:0] cmd [4] = '{16'h4520, 16'h4000, 16'h7FFF, 16'h0123};
      int n0;
      n0 = n_wr;
      foreach (cmd[i]) hwsf_serdes_model_i.send(cmd[i]);
      cyc(2);
      check("nwr", 16'(n_wr - n0), 16'h0003);
      check("thr5", {8'h0, thr[5]}, 16'h0020);
      check("thr63", {8'h0, thr[63]}, 16'h00FF);
      check("busy", {15'h0, sc_busy}, 16'h0);
   endtask : t_set
   task automatic t_overflow();
      repeat (8) beat(64'h5A, 1);
      settle();
      check("ovf", {15'h0, overflow}, 16'h1);
      exp_cnt += 16'h8;
   endtask : t_overflow
   task automatic t_init();
      int n0;
      n0 = n_wr;
      hwsf_serdes_model_i.send(16'h8000);
      settle();
      check("nwr", 16'(n_wr - n0), 16'h0040);
      check("thr63", {8'h0, thr[63]}, 16'h00FF);
      check("ovf", {15'h0, overflow}, 16'h0);
   endtask : t_init
   // A set sent during the reset walk must be ignored
   task automatic t_rst();
      int n0;
      n0 = n_wr;
      hwsf_serdes_model_i.send(16'hC000);
      hwsf_serdes_model_i.send(16'h4777);
      settle();
      check("nwr", 16'(n_wr - n0), 16'h0040);
      check("thr7", {8'h0, thr[7]}, 16'h0);
      check("thr63", {8'h0, thr[63]}, 16'h0);
      hwsf_serdes_model_i.got.delete();
      exp_cnt = 16'h0;
      beat(64'hF00D, 4);
      settle();
      frm(64'hF00D, 0);
   endtask : t_rst
   initial begin
      cyc(8);
      srst = 1'b0;
      cyc(1);
      t_frames();
      t_set();
      t_overflow();
      t_init();
      t_rst();
      summarize();
   end
endmodule : hwsf_framer_test
